// [src/clkgen_defs.vh]
// Purpose: constants for the clock generator and reset control block
// Assumes: pclk at 100 MHz
// Notes: offsets are byte addresses on APB
`ifndef CLKGEN_DEFS_VH
`define CLKGEN_DEFS_VH

`define CLK_PERIOD_NS 10
`define LOCK_TIME_US 750
`define LOCK_CYCLES ((`LOCK_TIME_US * 1000) / `CLK_PERIOD_NS)
`define SWRST_TIME_US 1
`define SWRST_CYCLES (((`SWRST_TIME_US * 1000) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define ADDR_CMD_ONE 12'h000
`define ADDR_CMD_TWO 12'h004
`define ADDR_STATUS 12'h008
`define ADDR_TUNE 12'h00C

// config_command_one fields
`define C1_SET_FREQ 0
`define C1_XTAL_32M 1
`define C1_REF_SEL_LO 2
`define C1_REF_SEL_HI 4
`define C1_REF_FAST 5
`define C1_CLK_MASTER 6
`define C1_PHASE_WR 7
`define C1_PHASE_EN 8
`define C1_OUT_EN_LO 16
`define C1_OUT_EN_HI 23

// config_command_two fields
`define C2_SW_RESET 0

// status fields
`define ST_LOCKED 0
`define ST_BYPASS 1
`define ST_SWRST 2
`define ST_FAST_CLK 3
`define ST_PHASE_EN 4
`define ST_DIG_LOOP 5
`define ST_BUSY 6

// reference selector codes
`define REF_FRAME_SYNC 3'h0
`define REF_BIT_CLOCK 3'h1
`define REF_NET_ONE 3'h2
`define REF_NET_TWO 3'h3
`define REF_OSC 3'h4

`define TUNE_W 8
`define TUNE_RESET 8'h00

`endif

// [src/coarse_tune.v]
// Purpose: coarse tuning up counter for the oscillator current
// Assumes: ref_tick and osc_tick are one-cycle pulses in pclk
// Notes: counts up while reference outruns the divided oscillator
`timescale 1ns/1ps
`include "clkgen_defs.vh"
module coarse_tune (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// control
	input wire run,
	input wire restart,
	// frequency events
	input wire ref_tick,
	input wire osc_tick,
	// result
	output reg [`TUNE_W-1:0] tune_r,
	output reg matched_r
);
	reg signed [3:0] diff_r;
	reg signed [3:0] diff_nxt;

	always @* begin
		diff_nxt = diff_r;
		if (ref_tick && !osc_tick)
			diff_nxt = diff_r + 4'sh1;
		else if (osc_tick && !ref_tick)
			diff_nxt = diff_r - 4'sh1;
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tune_r <= `TUNE_RESET;
			diff_r <= 4'sh0;
			matched_r <= 1'b0;
		end else if (restart) begin
			tune_r <= `TUNE_RESET;
			diff_r <= 4'sh0;
			matched_r <= 1'b0;
		end else if (run) begin
			if (diff_nxt > 4'sh1) begin
				diff_r <= 4'sh0;
				matched_r <= 1'b0;
				if (tune_r != {`TUNE_W{1'b1}})
					tune_r <= tune_r + 8'h01;
			end else if (diff_nxt < -4'sh1) begin
				diff_r <= 4'sh0;
				matched_r <= 1'b1;
			end else begin
				diff_r <= diff_nxt;
			end
		end
		// counter holds when neither running nor restarting
	end
endmodule

// [src/edge_tick.v]
// Purpose: rising edge detector producing a one-cycle pulse
// Assumes: input already synchronous to pclk
// Notes: used for reference and oscillator divider taps
`timescale 1ns/1ps
module edge_tick (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// signal
	input wire level,
	output reg tick_r
);
	reg last_r;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_r <= 1'b0;
			tick_r <= 1'b0;
		end else begin
			last_r <= level;
			tick_r <= level & ~last_r;
		end
	end
endmodule

// [src/pcm_clock_generator_reset.v]
// Purpose: reference selection, loop sequencing, lock status and reset control
// Assumes: reference inputs are synchronous to pclk; APB slave, zero wait states
// Notes: analogue multiplier is external; this block drives its controls
// Summary of operation
// - references at 2.048 MHz or above bypass the digital loop, go direct.
// - analogue loop multiplies 2.048 MHz to 49.152 MHz; outputs derive from it.
// - analogue loop bypassed after reset; locks 750 us after frequency command.
// - lock sets the loop-locked bit in the first interrupt status.
// - accepts 16.384 or 32.768 MHz crystal or external oscillator.
// - coarse loop runs at start, stops after 750 us, counter holds.
// - counter increments while reference outruns divided oscillator, until equal.
// - loop-unstable signal resets the coarse loop and restarts adjustment.
// - alignment on syncs all outputs to input; off syncs only main output.
// - after reset alignment is on as clock slave, off as master.
// - reference from frame sync, bit clock or networks; slow ones use digital loop.
// - analogue loop may also source from oscillator or bit clock directly.
// - hardware reset floats all outputs except the external clock output; here the other outputs are driven to their reset values, not floated.
// - internal clock 2.048 MHz while locking, 49.152 MHz after lock.
// - hardware reset clears state; output sections wait for enabling commands.
// - core reset leaves test port alone; test reset owns it.
// - software reset clears all but clocking and host registers; toggled off.
// - commands ignored for at least 1 us during software reset.
`timescale 1ns/1ps
`include "clkgen_defs.vh"
module pcm_clock_generator_reset #(
	parameter LOCK_CYCLES = `LOCK_CYCLES
) (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// reference inputs
	input wire frame_sync,
	input wire pcm_bit_clock,
	input wire net_ref_one,
	input wire net_ref_two,
	input wire ext_clock_input,
	input wire osc_div_tap,
	input wire loop_unstable,
	input wire clk_master_strap,
	// analogue loop control
	output reg analog_multiplier_loop_bypass,
	output reg analog_multiplier_loop_run,
	output reg digital_sync_loop_en,
	output reg [2:0] loop_ref_sel,
	output reg phase_align_en,
	output reg xtal_32m,
	output reg [7:0] coarse_current,
	output reg internal_clk_fast,
	// pins and resets
	output reg ext_clock_output,
	output reg [7:0] out_section_en,
	output reg core_soft_reset
);
	localparam ST_IDLE = 2'h0;
	localparam ST_LOCKING = 2'h1;
	localparam ST_LOCKED = 2'h2;
	// full-width copies, cut on purpose where they meet the counters
	localparam [31:0] LOCK_LAST = LOCK_CYCLES - 1;
	localparam [31:0] SWRST_LOAD = `SWRST_CYCLES;

	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg [19:0] lock_cnt_r;
	reg [7:0] swrst_cnt_r;
	reg [31:0] cmd_one_r;
	reg soft_rst_r;
	reg locked_flag_r;
	reg strap_done_r;
	reg xtal_pin_r;
	wire tune_run;
	wire [7:0] tune_val;
	wire tune_match;
	wire ref_tick;
	wire osc_tick;
	reg ref_level;

	// register decoding used by read and write paths
	function is_mapped;
		input [11:0] a;
		begin
			is_mapped = (a == `ADDR_CMD_ONE) || (a == `ADDR_CMD_TWO) ||
				(a == `ADDR_STATUS) || (a == `ADDR_TUNE);
		end
	endfunction

	wire setup = psel & ~penable;
	// writes land in the access phase, at the edge where the master sees pready
	wire access = psel & penable & pready;
	wire wr_any = access & pwrite & is_mapped(paddr);
	wire swrst_busy = (swrst_cnt_r != 8'h00);
	wire wr_cmd_one = wr_any & (paddr == `ADDR_CMD_ONE) & ~swrst_busy;
	wire wr_cmd_two = wr_any & (paddr == `ADDR_CMD_TWO) & ~swrst_busy;
	wire set_freq = wr_cmd_one & pwdata[`C1_SET_FREQ];
	wire ref_fast = cmd_one_r[`C1_REF_FAST];
	wire [2:0] ref_sel = cmd_one_r[`C1_REF_SEL_HI:`C1_REF_SEL_LO];

	always @* begin
		case (ref_sel)
			`REF_FRAME_SYNC: ref_level = frame_sync;
			`REF_BIT_CLOCK: ref_level = pcm_bit_clock;
			`REF_NET_ONE: ref_level = net_ref_one;
			`REF_NET_TWO: ref_level = net_ref_two;
			`REF_OSC: ref_level = ext_clock_input;
			default: ref_level = frame_sync;
		endcase
	end

	edge_tick ref_edge (
		.pclk(pclk),
		.presetn(presetn),
		.level(ref_level),
		.tick_r(ref_tick)
	);

	edge_tick osc_edge (
		.pclk(pclk),
		.presetn(presetn),
		.level(osc_div_tap),
		.tick_r(osc_tick)
	);

	// coarse loop active only while locking
	assign tune_run = (state_r == ST_LOCKING);

	coarse_tune tuner (
		.pclk(pclk),
		.presetn(presetn),
		.run(tune_run),
		.restart(loop_unstable),
		.ref_tick(ref_tick),
		.osc_tick(osc_tick),
		.tune_r(tune_val),
		.matched_r(tune_match)
	);

	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: if (set_freq) state_nxt = ST_LOCKING;
			ST_LOCKING: if (lock_cnt_r == LOCK_LAST[19:0]) state_nxt = ST_LOCKED;
			ST_LOCKED: if (loop_unstable) state_nxt = ST_LOCKING;
			default: state_nxt = ST_IDLE;
		endcase
		if (set_freq && state_r == ST_LOCKED)
			state_nxt = ST_LOCKING;
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ST_IDLE;
			lock_cnt_r <= 20'h00000;
		end else begin
			state_r <= state_nxt;
			if (state_nxt == ST_LOCKING && state_r != ST_LOCKING)
				lock_cnt_r <= 20'h00000;
			else if (state_r == ST_LOCKING)
				lock_cnt_r <= lock_cnt_r + 20'h00001;
		end
	end

	// strap caught after release, not in reset branch
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_done_r <= 1'b0;
			cmd_one_r <= 32'h00000000;
			soft_rst_r <= 1'b0;
			swrst_cnt_r <= 8'h00;
			locked_flag_r <= 1'b0;
			xtal_pin_r <= 1'b0;
		end else begin
			if (!strap_done_r) begin
				strap_done_r <= 1'b1;
				cmd_one_r[`C1_CLK_MASTER] <= clk_master_strap;
				cmd_one_r[`C1_PHASE_EN] <= ~clk_master_strap;
			end else if (wr_cmd_one) begin
				cmd_one_r <= pwdata;
				cmd_one_r[`C1_SET_FREQ] <= 1'b0;
				// alignment kept unless explicitly written
				if (!pwdata[`C1_PHASE_WR])
					cmd_one_r[`C1_PHASE_EN] <= cmd_one_r[`C1_PHASE_EN];
				if (soft_rst_r)
					cmd_one_r[`C1_OUT_EN_HI:`C1_OUT_EN_LO] <= 8'h00;
			end else if (soft_rst_r) begin
				cmd_one_r[`C1_OUT_EN_HI:`C1_OUT_EN_LO] <= 8'h00;
			end
			if (set_freq)
				xtal_pin_r <= pwdata[`C1_XTAL_32M];
			if (wr_cmd_two && pwdata[`C2_SW_RESET]) begin
				soft_rst_r <= ~soft_rst_r;
				swrst_cnt_r <= SWRST_LOAD[7:0];
			end else if (swrst_busy) begin
				swrst_cnt_r <= swrst_cnt_r - 8'h01;
			end
			// set wins over clear on read of status
			if (state_nxt == ST_LOCKED && state_r != ST_LOCKED)
				locked_flag_r <= 1'b1;
			else if (setup && !pwrite && paddr == `ADDR_STATUS)
				locked_flag_r <= 1'b0;
		end
	end

	// apb answer, zero wait states
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			pslverr <= setup & ~is_mapped(paddr);
			if (setup && !pwrite) begin
				case (paddr)
					`ADDR_CMD_ONE: prdata <= cmd_one_r;
					`ADDR_CMD_TWO: prdata <= {31'h00000000, soft_rst_r};
					`ADDR_STATUS: prdata <= {25'h0000000, swrst_busy, ~ref_fast,
						phase_align_en, internal_clk_fast, soft_rst_r,
						analog_multiplier_loop_bypass, locked_flag_r};
					`ADDR_TUNE: prdata <= {23'h000000, tune_match, tune_val};
					default: prdata <= 32'h00000000;
				endcase
			end
		end
	end

	// registered outputs
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			analog_multiplier_loop_bypass <= 1'b1;
			analog_multiplier_loop_run <= 1'b0;
			digital_sync_loop_en <= 1'b0;
			loop_ref_sel <= `REF_FRAME_SYNC;
			phase_align_en <= 1'b0;
			xtal_32m <= 1'b0;
			coarse_current <= `TUNE_RESET;
			internal_clk_fast <= 1'b0;
			out_section_en <= 8'h00;
			core_soft_reset <= 1'b0;
		end else begin
			analog_multiplier_loop_bypass <= (state_r != ST_LOCKED);
			analog_multiplier_loop_run <= (state_r != ST_IDLE);
			digital_sync_loop_en <= ~ref_fast && (ref_sel != `REF_OSC) &&
				(ref_sel != `REF_BIT_CLOCK);
			loop_ref_sel <= ref_sel;
			phase_align_en <= cmd_one_r[`C1_PHASE_EN];
			xtal_32m <= xtal_pin_r;
			coarse_current <= tune_val;
			internal_clk_fast <= (state_r == ST_LOCKED);
			out_section_en <= soft_rst_r ? 8'h00 :
				cmd_one_r[`C1_OUT_EN_HI:`C1_OUT_EN_LO];
			core_soft_reset <= soft_rst_r;
		end
	end

	// no reset on purpose: the one pin that keeps following its input through hardware reset
	always @(posedge pclk) begin
		ext_clock_output <= ext_clock_input;
	end
endmodule

// [verification/clkgen_asserts.sv]
// Purpose: port checks for the clock generator and reset control block
// Assumes: bound into the top module, pclk is the only clock
// Notes: lock window allows some pipeline slack
`timescale 1ns/1ps
module clkgen_asserts #(
	parameter LOCK_CYCLES = 50
) (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// apb request
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	// far side inputs
	input wire loop_unstable,
	input wire clk_master_strap,
	input wire ext_clock_input,
	// watched outputs
	input wire ext_clock_output,
	input wire core_soft_reset,
	input wire phase_align_en,
	input wire analog_multiplier_loop_bypass,
	input wire analog_multiplier_loop_run,
	input wire internal_clk_fast,
	input wire digital_sync_loop_en,
	input wire [2:0] loop_ref_sel,
	input wire [7:0] coarse_current,
	input wire [7:0] out_section_en
);
	int lock_n;
	wire byp = analog_multiplier_loop_bypass;
	wire wr1 = psel && !penable && pwrite && paddr == 12'h000;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			lock_n <= 0;
		else if (analog_multiplier_loop_run && byp)
			lock_n <= lock_n + 1;
		else
			lock_n <= 0;
	end
	sequence rel_s;
		$rose(presetn);
	endsequence
	sequence soft_on_s;
		$rose(core_soft_reset);
	endsequence
	reset_state_a: assert property (rel_s |-> byp && !internal_clk_fast
		&& out_section_en == 8'h00) else $error("reset state");
	lock_time_a: assert property ($fell(byp) |->
		lock_n >= LOCK_CYCLES - 2 && lock_n <= LOCK_CYCLES + 3) else $error("lock time");
	fast_clk_a: assert property ($fell(byp) |-> ##[0:1] internal_clk_fast)
		else $error("clock not fast");
	phase_slave_a: assert property (rel_s ##0 !clk_master_strap |-> ##[1:3] phase_align_en)
		else $error("alignment off");
	slow_loop_a: assert property (digital_sync_loop_en |->
		loop_ref_sel != 3'h1 && loop_ref_sel != 3'h4) else $error("loop not bypassed");
	unstable_a: assert property (loop_unstable && !byp |-> ##[1:2] byp)
		else $error("no relock");
	coarse_hold_a: assert property (!byp && $past(!byp) && !$past(loop_unstable)
		|-> $stable(coarse_current)) else $error("counter moved");
	soft_clear_a: assert property (soft_on_s |-> ##2 (out_section_en == 8'h00) [*8])
		else $error("sections on");
	out_cause_a: assert property ($past(presetn) && $changed(out_section_en) |->
		$past(wr1, 3) || core_soft_reset) else $error("sections moved");
	ext_clock_a: assert property ($past(presetn) |->
		ext_clock_output == $past(ext_clock_input)) else $error("clock output");
endmodule
bind pcm_clock_generator_reset clkgen_asserts #(.LOCK_CYCLES(LOCK_CYCLES)) u_chk (.*);

// [verification/ref_source.sv]
// Purpose: reference and oscillator levels for the clock generator
// Assumes: all levels synchronous to pclk
// Notes: bit clock and network refs outrun the divided oscillator so coarse tuning climbs
`timescale 1ns/1ps
module ref_source (
	// clock
	input wire pclk,
	// reference levels
	output logic frame_sync,
	output logic pcm_bit_clock,
	output logic net_ref_one,
	output logic net_ref_two,
	// crystal and divided oscillator
	output logic ext_clock_input,
	output logic osc_div_tap
);
	logic [13:0] c = 14'h0000;
	always @(posedge pclk)
		c <= (c == 14'h30D3) ? 14'h0000 : c + 14'h0001;
	// one marker per 12500 cycles
	assign frame_sync = c < 14'h0010;
	// true crystal rate is no divisor of pclk
	assign ext_clock_input = c[0];
	assign pcm_bit_clock = c[1];
	assign net_ref_one = c[2];
	assign net_ref_two = c[3];
	assign osc_div_tap = c[5];
endmodule

// [verification/pcm_clock_generator_reset_test.sv]
// Purpose: self-checking bench for the clock generator and reset control
// Assumes: short lock count, zero-wait APB slave
// Notes: a monitor pops one queued note per pready
`timescale 1ns/1ps
`include "clkgen_defs.vh"
module pcm_clock_generator_reset_test;
	localparam int LOCK_CYCLES = 50;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic loop_unstable = 1'b0, clk_master_strap = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	wire [31:0] prdata;
	wire pready, pslverr, frame_sync, pcm_bit_clock, net_ref_one, net_ref_two, osc_div_tap;
	wire ext_clock_input, ext_clock_output, analog_multiplier_loop_bypass, xtal_32m;
	wire analog_multiplier_loop_run, digital_sync_loop_en, phase_align_en;
	wire internal_clk_fast, core_soft_reset;
	wire [2:0] loop_ref_sel;
	wire [7:0] coarse_current, out_section_en;
	logic [64:0] q[$];
	logic [64:0] n;
	logic [7:0] r;
	int miscompares = 0, n_checks = 0;
	always #5 pclk = ~pclk;
	ref_source i_ref (.*);
	pcm_clock_generator_reset #(.LOCK_CYCLES(LOCK_CYCLES)) i_dut (.*);
	task automatic print_verdict;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %0t exp %h got %h", $time, e, g);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge pclk);
	endtask
	// read data and error are noted here, compared by the monitor
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [31:0] m, input logic e);
		q.push_back({e, m, d});
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		tick(1);
		penable <= 1'b1;
		tick(1);
		while (pready !== 1'b1)
			tick(1);
		psel <= 1'b0;
		penable <= 1'b0;
		// write lands at the access edge, its outputs one edge later
		tick(2);
	endtask
	task automatic hw_reset(input logic m, input int k);
		presetn <= 1'b0;
		clk_master_strap <= m;
		tick(k);
		presetn <= 1'b1;
		tick(3);
	endtask
	always @(posedge pclk)
		if (pready === 1'b1) begin
			n = q.pop_front();
			cmp(n[31:0] & n[63:32], prdata & n[63:32]);
			cmp(32'(n[64]), 32'(pslverr));
		end
	initial begin
		#200000;
		miscompares++;
		print_verdict();
	end
	initial begin
		void'($urandom(32'hEE7D));
		hw_reset(1'b0, 6);
		cmp(32'({analog_multiplier_loop_bypass, internal_clk_fast, phase_align_en,
			out_section_en}), 32'h500);
		xfer(0, `ADDR_STATUS, 32'h12, 32'h1B, 0);
		xfer(0, 12'h010, 0, 32'hFFFFFFFF, 1);
		xfer(1, `ADDR_CMD_ONE, 32'h0B, 0, 0);
		tick(LOCK_CYCLES - 8);
		cmp(32'({xtal_32m, analog_multiplier_loop_run, analog_multiplier_loop_bypass,
			internal_clk_fast}), 32'hE);
		tick(12);
		cmp(32'({analog_multiplier_loop_bypass, internal_clk_fast}), 32'h1);
		cmp(32'(coarse_current != 8'h00), 32'h1);
		xfer(0, `ADDR_STATUS, 32'h9, 32'hB, 0);
		xfer(0, `ADDR_STATUS, 0, 32'h1, 0);
		r = coarse_current;
		tick(20);
		cmp(32'(coarse_current), 32'(r));
		for (int i = 0; i < 10; i++) begin
			r = 8'($urandom);
			xfer(1, `ADDR_CMD_ONE, {8'h00, r, 10'h000, i[0], i[3:1], 2'b00}, 0, 0);
			cmp(32'({loop_ref_sel, digital_sync_loop_en, out_section_en}), 32'({i[3:1],
				!i[0] && i[3:1] != 1 && i[3:1] != 4, r}));
		end
		xfer(1, `ADDR_CMD_ONE, 32'h088, 0, 0);
		cmp(32'(phase_align_en), 32'h0);
		xfer(1, `ADDR_CMD_ONE, 32'h188, 0, 0);
		cmp(32'(phase_align_en), 32'h1);
		xfer(1, `ADDR_CMD_ONE, 32'h008, 0, 0);
		cmp(32'(phase_align_en), 32'h1);
		loop_unstable <= 1'b1;
		tick(1);
		loop_unstable <= 1'b0;
		tick(3);
		cmp(32'({analog_multiplier_loop_bypass, internal_clk_fast}), 32'h2);
		tick(LOCK_CYCLES + 10);
		cmp(32'({analog_multiplier_loop_bypass, internal_clk_fast}), 32'h1);
		xfer(1, `ADDR_CMD_TWO, 32'h1, 0, 0);
		xfer(1, `ADDR_CMD_ONE, 32'h00FF0090, 0, 0);
		xfer(0, `ADDR_CMD_TWO, 32'h1, 32'h1, 0);
		cmp(32'({loop_ref_sel, phase_align_en}), 32'h5);
		cmp(32'({core_soft_reset, out_section_en, internal_clk_fast}), 32'h201);
		tick(100);
		xfer(1, `ADDR_CMD_TWO, 32'h1, 0, 0);
		tick(100);
		xfer(1, `ADDR_CMD_ONE, 32'h005A0008, 0, 0);
		cmp(32'({core_soft_reset, out_section_en, internal_clk_fast}), 32'h0B5);
		hw_reset(1'b1, 100);
		cmp(32'({analog_multiplier_loop_bypass, internal_clk_fast, phase_align_en,
			out_section_en, analog_multiplier_loop_run}), 32'h800);
		print_verdict();
	end
endmodule
